// [adc_ctrl_defs.vh]
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// ==========================================================
// System clock
`define SYS_CLK_PERIOD_NS   100
`define SCLK_MAX_FREQ_KHZ   8000

// ==========================================================
// Conversion framing, counted in serial clock edges
`define FALL_CNT_W          5
`define RISE_CNT_W          4
`define FALL_IDLE           5'h00
`define FALL_FIRST          5'h01
`define FALL_TRACK_LAST     5'h03
`define FALL_HOLD_START     5'h04
`define FALL_LAST_BIT       5'h0f
`define FALL_CONV_END       5'h10
`define RISE_CTRL_LAST      4'h7

// ==========================================================
// Control byte layout
`define CTRL_W              8
`define CTRL_ADDR_HIGH      5
`define CTRL_ADDR_MID       4
`define CTRL_ADDR_LOW       3
`define CTRL_RESET          8'h00
`define CHAN_RESET          2'h0

// ==========================================================
// Result format and buffering
`define CODE_W              12
`define CODE_MSB            11
`define CHAN_W              2
`define RESULT_W            14
`define RESULT_DEPTH        16

`endif

// [adc_sync2.v]
`timescale 1ns/100ps

// ==========================================================
// Two-stage synchroniser, one stage pair per bit
module adc_sync2
#(
  parameter       W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  genvar g;

  // ========================================================
  // Per bit: first stage feeds only the second stage
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          meta_r <= RST_VAL[g];
          sync_r <= RST_VAL[g];
        end
        else
        begin
          meta_r <= async_i[g];
          sync_r <= meta_r;
        end
      end
      assign sync_o[g] = sync_r;
    end
  endgenerate

endmodule // adc_sync2

// [adc_result_fifo.v]
`timescale 1ns/100ps

// ==========================================================
// Result FIFO with registered output stage
module adc_result_fifo
#(
  parameter WIDTH = 14,
  parameter DEPTH = 16
)
(
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output reg  [WIDTH-1:0] out_data_o,
  output reg              out_valid_o,
  input  wire             out_ready_i
);

  localparam AW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            load;

  // Handshakes on both sides
  assign in_ready_o = (count_r != DEPTH[AW:0]);
  assign push       = in_valid_i && in_ready_o;
  assign load       = (count_r != {(AW+1){1'b0}}) &&
                      (!out_valid_o || out_ready_i);

  // ========================================================
  // Storage array, no reset needed
  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data_i;
  end

  // ========================================================
  // Pointers, fill level and output stage
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      count_r     <= {(AW+1){1'b0}};
      out_data_o  <= {WIDTH{1'b0}};
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (load)
      begin
        rd_ptr_r   <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
        out_data_o <= mem[rd_ptr_r];
      end
      // Output stage empties when taken unless refilled
      if (load)
        out_valid_o <= 1'b1;
      else if (out_ready_i)
        out_valid_o <= 1'b0;
      if (push && !load)
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      else if (load && !push)
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // adc_result_fifo

// [adc_serial_ctrl.v]
// Overview of operation
// - Simultaneous frame and clock fall: frame fall counts as first fall
// - First frame after reset converts validly
// - Before any control byte, input one converts
// - Control byte MSB first, bits 5..3 address
// - Two low address bits select channel next
// - Result is 12-bit straight binary code
// - Active with frame low, powered down high
// - Powered down from 16th fall to next 1st
// - Conversions are 16 clocks, back to back
// - Conversions repeat while frame select stays low
// - Track three cycles, hold and convert twelve
// - Result MSB first from fourth clock cycle
// - Control byte taken on first eight rises
`timescale 1ns/100ps
`include "adc_ctrl_defs.vh"

module adc_serial_ctrl
(
  input  wire                 CLOCK_I,
  input  wire                 NRST_I,
  input  wire                 FRAME_SEL_N_I,
  input  wire                 SERIAL_CLK_I,
  input  wire                 SERIAL_IN_I,
  output reg                  SERIAL_OUT_O,
  output reg                  SERIAL_OUT_OE_N_O,
  input  wire [`CODE_W-1:0]   ANALOG_INPUT_1_I,
  input  wire [`CODE_W-1:0]   ANALOG_INPUT_2_I,
  input  wire [`CODE_W-1:0]   ANALOG_INPUT_3_I,
  input  wire [`CODE_W-1:0]   ANALOG_INPUT_4_I,
  output reg                  POWER_DOWN_O,
  output reg                  TRACK_O,
  output reg                  CONVERT_O,
  output reg  [`CHAN_W-1:0]   CHANNEL_O,
  output reg  [`CTRL_W-1:0]   CONTROL_O,
  output wire [`CODE_W-1:0]   RESULT_CODE_O,
  output wire [`CHAN_W-1:0]   RESULT_CHAN_O,
  output wire                 RESULT_VALID_O,
  input  wire                 RESULT_READY_I,
  output reg                  RESULT_ROOM_O,
  output reg                  RESULT_LOST_O
);

  // ========================================================
  // Declarations
  wire [2:0]            pins_sync;
  wire                  frame_n_s;
  wire                  sclk_s;
  wire                  din_s;
  reg                   frame_n_d_r;
  reg                   sclk_d_r;
  wire                  frame_fall;
  wire                  frame_active;
  wire                  sclk_rise;
  wire                  sclk_fall;

  reg  [`FALL_CNT_W-1:0] fall_cnt_r;
  reg  [`FALL_CNT_W-1:0] fall_cnt_nxt;
  reg  [`RISE_CNT_W-1:0] rise_cnt_r;
  reg  [`CTRL_W-2:0]     ctrl_shift_r;
  wire [`CTRL_W-1:0]     ctrl_byte;
  reg  [`CHAN_W-1:0]     pending_chan_r;
  reg  [`CHAN_W-1:0]     cur_chan_r;
  reg  [`CODE_W-1:0]     sel_code;
  reg  [`CODE_W-1:0]     held_code_r;
  reg  [`CODE_W-1:0]     out_shift_r;
  reg  [`CHAN_W-1:0]     done_chan_r;

  wire                   conv_start;
  wire                   hold_start;
  wire                   conv_done;
  reg                    push_r;
  reg  [`RESULT_W-1:0]   push_data_r;
  wire                   fifo_in_ready;
  wire [`RESULT_W-1:0]   fifo_out_data;

  // ========================================================
  // Pin synchronisers: frame select idles high
  adc_sync2
  #(
    .W       (3),
    .RST_VAL (3'h1)
  )
  u_sync
  (
    .clk_i   (CLOCK_I),
    .nrst_i  (NRST_I),
    .async_i ({SERIAL_IN_I, SERIAL_CLK_I, FRAME_SEL_N_I}),
    .sync_o  (pins_sync)
  );

  assign frame_n_s = pins_sync[0];
  assign sclk_s    = pins_sync[1];
  assign din_s     = pins_sync[2];

  // ========================================================
  // Edge detection on synchronised levels
  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      frame_n_d_r <= 1'b1;
      sclk_d_r    <= 1'b0;
    end
    else
    begin
      frame_n_d_r <= frame_n_s;
      sclk_d_r    <= sclk_s;
    end
  end

  // Clock edges only count inside a frame
  assign frame_fall   = frame_n_d_r && !frame_n_s;
  assign frame_active = !frame_n_s && !frame_n_d_r;
  assign sclk_rise    = frame_active && sclk_s && !sclk_d_r;
  assign sclk_fall    = frame_active && !sclk_s && sclk_d_r;

  // ========================================================
  // Falling-edge position within a conversion
  always @*
  begin
    fall_cnt_nxt = fall_cnt_r;
    if (frame_n_s)
      fall_cnt_nxt = `FALL_IDLE;
    else if (frame_fall)
    begin
      // Clock already low: frame fall is the first fall
      if (!sclk_s)
        fall_cnt_nxt = `FALL_FIRST;
      else
        fall_cnt_nxt = `FALL_IDLE;
    end
    else if (sclk_fall)
    begin
      // Wrap straight into the next conversion
      if (fall_cnt_r == `FALL_CONV_END)
        fall_cnt_nxt = `FALL_FIRST;
      else
        fall_cnt_nxt = fall_cnt_r + {{(`FALL_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      fall_cnt_r <= `FALL_IDLE;
    else
      fall_cnt_r <= fall_cnt_nxt;
  end

  // Conversion phase events
  assign conv_start = (fall_cnt_nxt == `FALL_FIRST) &&
                      (fall_cnt_r != `FALL_FIRST);
  assign hold_start = sclk_fall &&
                      (fall_cnt_nxt == `FALL_HOLD_START);
  assign conv_done  = sclk_fall &&
                      (fall_cnt_nxt == `FALL_CONV_END);

  // ========================================================
  // Rising-edge count, restarted by each frame
  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      rise_cnt_r <= {`RISE_CNT_W{1'b0}};
    else if (frame_n_s)
      rise_cnt_r <= {`RISE_CNT_W{1'b0}};
    else if (sclk_rise)
      rise_cnt_r <= rise_cnt_r + {{(`RISE_CNT_W-1){1'b0}}, 1'b1};
  end

  // Full byte once the eighth bit arrives
  assign ctrl_byte = {ctrl_shift_r, din_s};

  // ========================================================
  // Control byte capture on the first eight rises
  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ctrl_shift_r   <= {(`CTRL_W-1){1'b0}};
      CONTROL_O      <= `CTRL_RESET;
      pending_chan_r <= `CHAN_RESET;
    end
    else if (sclk_rise && (rise_cnt_r <= `RISE_CTRL_LAST))
    begin
      ctrl_shift_r <= ctrl_byte[`CTRL_W-2:0];
      if (rise_cnt_r == `RISE_CTRL_LAST)
      begin
        CONTROL_O      <= ctrl_byte;
        // High address bit and spare bits play no part
        pending_chan_r <= {ctrl_byte[`CTRL_ADDR_MID],
                           ctrl_byte[`CTRL_ADDR_LOW]};
      end
    end
  end

  // ========================================================
  // Channel in use, taken at the start of each track phase
  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      cur_chan_r <= `CHAN_RESET;
    else if (conv_start)
      cur_chan_r <= pending_chan_r;
  end

  // Input multiplexer
  always @*
  begin
    case (cur_chan_r)
      2'h0:    sel_code = ANALOG_INPUT_1_I;
      2'h1:    sel_code = ANALOG_INPUT_2_I;
      2'h2:    sel_code = ANALOG_INPUT_3_I;
      2'h3:    sel_code = ANALOG_INPUT_4_I;
      default: sel_code = ANALOG_INPUT_1_I;
    endcase
  end

  // ========================================================
  // Track while phase is 1..3, freeze sample at hold
  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      held_code_r <= {`CODE_W{1'b0}};
    else if (TRACK_O || conv_start)
      held_code_r <= sel_code;
  end

  // ========================================================
  // Serial output: leading zeros, then result MSB first
  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      out_shift_r  <= {`CODE_W{1'b0}};
      SERIAL_OUT_O <= 1'b0;
    end
    else if (frame_n_s || frame_fall)
    begin
      out_shift_r  <= {`CODE_W{1'b0}};
      SERIAL_OUT_O <= 1'b0;
    end
    else if (hold_start)
    begin
      // Straight binary code, first bit in cycle four
      out_shift_r  <= {held_code_r[`CODE_W-2:0], 1'b0};
      SERIAL_OUT_O <= held_code_r[`CODE_MSB];
    end
    else if (sclk_fall)
    begin
      out_shift_r  <= {out_shift_r[`CODE_W-2:0], 1'b0};
      SERIAL_OUT_O <= out_shift_r[`CODE_MSB];
    end
  end

  // ========================================================
  // Driver enable and power status
  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      SERIAL_OUT_OE_N_O <= 1'b1;
      POWER_DOWN_O      <= 1'b1;
      TRACK_O           <= 1'b0;
      CONVERT_O         <= 1'b0;
      CHANNEL_O         <= `CHAN_RESET;
    end
    else
    begin
      SERIAL_OUT_OE_N_O <= frame_n_s;
      // Down while deselected or after the sixteenth fall
      POWER_DOWN_O      <= frame_n_s ||
                           (fall_cnt_nxt == `FALL_CONV_END);
      TRACK_O           <= (fall_cnt_nxt >= `FALL_FIRST) &&
                           (fall_cnt_nxt <= `FALL_TRACK_LAST);
      CONVERT_O         <= (fall_cnt_nxt >= `FALL_HOLD_START) &&
                           (fall_cnt_nxt <= `FALL_LAST_BIT);
      if (conv_start)
        CHANNEL_O <= pending_chan_r;
    end
  end

  // ========================================================
  // Completed conversions queued toward the result port
  always @(posedge CLOCK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      push_r        <= 1'b0;
      push_data_r   <= {`RESULT_W{1'b0}};
      done_chan_r   <= `CHAN_RESET;
      RESULT_ROOM_O <= 1'b1;
      RESULT_LOST_O <= 1'b0;
    end
    else
    begin
      if (hold_start)
        done_chan_r <= cur_chan_r;
      push_r        <= conv_done && fifo_in_ready;
      push_data_r   <= {done_chan_r, held_code_r};
      RESULT_ROOM_O <= fifo_in_ready;
      // Pulse when a finished result finds the queue full
      RESULT_LOST_O <= conv_done && !fifo_in_ready;
    end
  end

  // ========================================================
  // Result buffer
  adc_result_fifo
  #(
    .WIDTH (`RESULT_W),
    .DEPTH (`RESULT_DEPTH)
  )
  u_fifo
  (
    .clk_i       (CLOCK_I),
    .nrst_i      (NRST_I),
    .in_data_i   (push_data_r),
    .in_valid_i  (push_r),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (RESULT_VALID_O),
    .out_ready_i (RESULT_READY_I)
  );

  // Result word split into code and channel
  assign RESULT_CODE_O = fifo_out_data[`CODE_W-1:0];
  assign RESULT_CHAN_O = fifo_out_data[`RESULT_W-1:`CODE_W];

endmodule // adc_serial_ctrl

// [adc_serial_ctrl_sva.sv]
`timescale 1ns/100ps
`include "adc_ctrl_defs.vh"

// ==========================================================
// Port checker for the serial converter control block
module adc_serial_ctrl_sva
(
  input wire                 CLOCK_I,
  input wire                 NRST_I,
  input wire                 FRAME_SEL_N_I,
  input wire                 SERIAL_OUT_O,
  input wire                 SERIAL_OUT_OE_N_O,
  input wire                 POWER_DOWN_O,
  input wire                 TRACK_O,
  input wire                 CONVERT_O,
  input wire [`CHAN_W-1:0]   CHANNEL_O,
  input wire [`CODE_W-1:0]   RESULT_CODE_O,
  input wire [`CHAN_W-1:0]   RESULT_CHAN_O,
  input wire                 RESULT_VALID_O,
  input wire                 RESULT_READY_I,
  input wire                 RESULT_ROOM_O,
  input wire                 RESULT_LOST_O
);
  default clocking cb
    @(posedge CLOCK_I);
  endclocking
  default disable iff (!NRST_I);

  // ==========================================================
  // Frame level versus pin and power state
  released_out_a: assert property (
    FRAME_SEL_N_I [*5] |-> SERIAL_OUT_OE_N_O && !SERIAL_OUT_O)
    else $error("output not released while frame high");
  asleep_high_a: assert property (
    FRAME_SEL_N_I [*5] |-> POWER_DOWN_O && !TRACK_O && !CONVERT_O)
    else $error("active while frame high");
  driven_low_a: assert property (
    !FRAME_SEL_N_I [*5] |-> !SERIAL_OUT_OE_N_O)
    else $error("output not driven while frame low");

  // ==========================================================
  // Conversion phases
  mode_excl_a: assert property (
    !(TRACK_O && CONVERT_O) && !(POWER_DOWN_O && (TRACK_O || CONVERT_O)))
    else $error("phase outputs overlap");
  track_min_a: assert property (
    $rose(TRACK_O) |=> TRACK_O [*8])
    else $error("track phase too short");
  hold_after_a: assert property (
    $fell(TRACK_O) |-> CONVERT_O || POWER_DOWN_O)
    else $error("track not followed by convert");
  sleep_after_a: assert property (
    $fell(CONVERT_O) |-> POWER_DOWN_O)
    else $error("no power down after conversion");
  track_first_a: assert property (
    $rose(CONVERT_O) |-> $past(TRACK_O) && !POWER_DOWN_O)
    else $error("convert without track");
  chan_steady_a: assert property (
    CONVERT_O |=> $stable(CHANNEL_O))
    else $error("channel moved during conversion");

  // ==========================================================
  // Result stream
  head_hold_a: assert property (
    RESULT_VALID_O && !RESULT_READY_I |=> RESULT_VALID_O
      && $stable(RESULT_CODE_O) && $stable(RESULT_CHAN_O))
    else $error("result head changed before taken");
  lost_full_a: assert property (
    RESULT_LOST_O |-> !RESULT_ROOM_O && RESULT_VALID_O)
    else $error("result dropped with room left");

  // Main scenarios reached
  cover property (RESULT_LOST_O);
  cover property ($fell(CONVERT_O) ##[1:200] $rose(TRACK_O));
  cover property (RESULT_VALID_O && RESULT_READY_I);
  cover property ($fell(POWER_DOWN_O) && !TRACK_O);
endmodule // adc_serial_ctrl_sva

// [adc_host_model.sv]
`timescale 1ns/100ps

// ==========================================================
// Host serial master: frame, clock and control bytes
module adc_host_model
(
  input  wire clk_i,
  input  wire dout_i,
  output reg  frame_n_o,
  output reg  sclk_o,
  output reg  din_o
);
  reg [7:0]  ctrl_q [0:31];
  reg [11:0] code_q [0:31];
  integer    c;
  integer    k;

  // Idle: frame high, clock parked low
  initial
  begin
    frame_n_o = 1'b1;
    sclk_o    = 1'b0;
    din_o     = 1'b0;
  end

  task wait_clk(input integer n);
    repeat (n) @(posedge clk_i);
  endtask

  // Clock edges while frame is high; odd n from a low clock ends with clock high
  task stray(input integer n);
    repeat (n)
    begin
      wait_clk(4);
      sclk_o <= ~sclk_o;
    end
  endtask

  // One frame of n whole conversions, 800 ns clock
  // With hi set, frame falls while clock is parked high
  task run_frame(input integer n, input logic hi);
  begin
    @(posedge clk_i);
    if (hi)
    begin
      sclk_o <= 1'b1;
      wait_clk(4);
      frame_n_o <= 1'b0;
      wait_clk(4);
    end
    frame_n_o <= 1'b0;
    sclk_o    <= 1'b0;
    for (c = 0; c < n; c = c + 1)
      for (k = 1; k <= 16; k = k + 1)
      begin
        if (k <= 8)
          din_o <= ctrl_q[c][8-k]; // Next channel, MSB first
        wait_clk(4);
        sclk_o <= 1'b1;
        wait_clk(4);
        if (k >= 4 && k <= 15)
          code_q[c] <= {code_q[c][10:0], dout_i};
        if (k < 16 || c < n - 1)
          sclk_o <= 1'b0;
        else
          frame_n_o <= 1'b1;
      end
    din_o <= ~din_o; // Released line shows no stale level
    wait_clk(4);
    sclk_o <= 1'b0;
  end
  endtask
endmodule // adc_host_model

// [adc_serial_ctrl_bench.sv]
`timescale 1ns/100ps
`include "adc_ctrl_defs.vh"

// ==========================================================
// Bench top
module adc_serial_ctrl_bench;
  reg                clk;
  reg                nrst;
  reg                rready;
  reg  [11:0]        ain [0:3];
  reg  [1:0]         pend;
  reg                lost_seen;
  integer            bad_count;
  integer            check_count;
  wire               frame_n;
  wire               sclk;
  wire               din;
  wire               dout;
  wire               dout_oe_n;
  wire               pd;
  wire               trk;
  wire               cnv;
  wire [1:0]         chan;
  wire [7:0]         ctrl;
  wire [11:0]        rcode;
  wire [1:0]         rchan;
  wire               rvalid;
  wire               room;
  wire               lost;

  // Clock, 100 ns period
  initial clk = 1'b0;
  always #50 clk = ~clk;

  adc_serial_ctrl i_dut (.CLOCK_I(clk), .NRST_I(nrst),
    .FRAME_SEL_N_I(frame_n), .SERIAL_CLK_I(sclk), .SERIAL_IN_I(din),
    .SERIAL_OUT_O(dout), .SERIAL_OUT_OE_N_O(dout_oe_n),
    .ANALOG_INPUT_1_I(ain[0]), .ANALOG_INPUT_2_I(ain[1]),
    .ANALOG_INPUT_3_I(ain[2]), .ANALOG_INPUT_4_I(ain[3]),
    .POWER_DOWN_O(pd), .TRACK_O(trk), .CONVERT_O(cnv), .CHANNEL_O(chan),
    .CONTROL_O(ctrl), .RESULT_CODE_O(rcode), .RESULT_CHAN_O(rchan),
    .RESULT_VALID_O(rvalid), .RESULT_READY_I(rready),
    .RESULT_ROOM_O(room), .RESULT_LOST_O(lost));

  adc_host_model i_host (.clk_i(clk), .dout_i(dout),
    .frame_n_o(frame_n), .sclk_o(sclk), .din_o(din));

  // Remember any dropped result
  always @(posedge clk)
    if (lost === 1'b1)
      lost_seen <= 1'b1;

  task summarize;
  begin
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  task chk(input string nm, input [13:0] exp, input logic [13:0] got);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask

  // Control byte for conversion c: channel c mod 4, filler varied
  function [7:0] byte_of(input integer c);
    byte_of = {~c[0], c[0], c[2], c[1], c[0], ~c[1], c[0], 1'b1};
  endfunction

  task reset_values;
  begin
    @(negedge clk);
    chk("pd", 1'b1, pd);
    chk("oe_n", 1'b1, dout_oe_n);
    chk("valid", 1'b0, rvalid);
    chk("room", 1'b1, room);
    chk("chan", 2'h0, chan);
  end
  endtask

  // Frame of n conversions, then drain and judge the results
  task conv_frame(input integer n, input logic hi);
    integer c;
    integer t;
    reg [1:0] ch;
  begin
    lost_seen = 1'b0;
    for (c = 0; c < n; c = c + 1)
      i_host.ctrl_q[c] = byte_of(c);
    i_host.run_frame(n, hi);
    @(negedge clk);
    chk("control", byte_of(n - 1), ctrl);
    chk("convert", 1'b0, cnv);
    chk("room", n < 17, room);
    for (c = 0; c < n; c = c + 1)
    begin
      ch = (c == 0) ? pend : c[1:0] - 2'h1;
      chk("serial", ain[ch], i_host.code_q[c]);
      if (c < 17)
      begin
        t = 0;
        @(negedge clk);
        while (rvalid !== 1'b1 && t < 60)
        begin
          @(negedge clk);
          t = t + 1;
        end
        chk("valid", 1'b1, rvalid);
        if (rvalid !== 1'b1)
          summarize;
        chk("chan", ch, rchan);
        chk("code", ain[ch], rcode);
        @(posedge clk);
        rready <= 1'b1;
        @(posedge clk);
        rready <= 1'b0;
      end
    end
    chk("chan_out", ch, chan);
    @(negedge clk);
    chk("drained", 1'b0, rvalid);
    chk("lost", n > 17, lost_seen);
    pend = n[1:0] - 2'h1;
  end
  endtask

  // Clock activity with frame high changes nothing
  task stray_clock;
  begin
    i_host.stray(5);
    @(negedge clk);
    chk("oe_n", 1'b1, dout_oe_n);
    chk("pd", 1'b1, pd);
    chk("track", 1'b0, trk);
  end
  endtask

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    rready = 1'b0;
    lost_seen = 1'b0;
    pend = 2'h0;
    bad_count = 0;
    check_count = 0;
    ain[0] = 12'hfff;
    ain[1] = 12'h000;
    ain[2] = 12'ha5c;
    ain[3] = 12'h5a3;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    reset_values;
    conv_frame(1, 1'b0);
    stray_clock;
    conv_frame(5, 1'b0);
    conv_frame(18, 1'b0);
    conv_frame(2, 1'b1);
    summarize;
  end
endmodule // adc_serial_ctrl_bench

bind adc_serial_ctrl adc_serial_ctrl_sva i_sva (.CLOCK_I(CLOCK_I),
  .NRST_I(NRST_I), .FRAME_SEL_N_I(FRAME_SEL_N_I),
  .SERIAL_OUT_O(SERIAL_OUT_O), .SERIAL_OUT_OE_N_O(SERIAL_OUT_OE_N_O),
  .POWER_DOWN_O(POWER_DOWN_O), .TRACK_O(TRACK_O), .CONVERT_O(CONVERT_O),
  .CHANNEL_O(CHANNEL_O), .RESULT_CODE_O(RESULT_CODE_O),
  .RESULT_CHAN_O(RESULT_CHAN_O), .RESULT_VALID_O(RESULT_VALID_O),
  .RESULT_READY_I(RESULT_READY_I), .RESULT_ROOM_O(RESULT_ROOM_O),
  .RESULT_LOST_O(RESULT_LOST_O));
